/* File: rtl/dma_channel.v */
// One DMA channel engine with Basic and Ping-Pong operation and an AHB-Lite register slave
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "dma_channel_defines.vh"
module dma_channel #(
	parameter [4:0] CHAN = 5'd8 // Channel number, selects bit and table slot
) (
	input wire sys_clk, // System clock, 20 MHz
	input wire nrst, // Synchronous reset, active low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size, words only
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg [31:0] hrdata, // AHB read data
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	output reg mem_req, // Memory access request, held until mem_ready
	output reg [31:0] mem_addr, // Memory byte address
	output reg mem_write, // Memory access is a write
	output reg [1:0] mem_size, // 0 byte, 1 half, 2 word
	output reg [31:0] mem_wdata, // Write data, right aligned
	input wire mem_ready, // Memory access completes
	input wire [31:0] mem_rdata, // Read data, right aligned
	input wire periph_single_req, // Peripheral single request
	input wire periph_burst_req, // Peripheral burst request
	output reg periph_done, // Completion interrupt pulse
	output reg high_priority, // Channel priority to the arbiter
	output reg channel_active // Channel is serving a request
);

	// One-hot sequencer states; the status register shows them as they stand
	localparam [6:0] S_IDLE = 7'b0000001;
	localparam [6:0] S_FSRC = 7'b0000010;
	localparam [6:0] S_FDST = 7'b0000100;
	localparam [6:0] S_FCTL = 7'b0001000;
	localparam [6:0] S_RD = 7'b0010000;
	localparam [6:0] S_WR = 7'b0100000;
	localparam [6:0] S_WB = 7'b1000000;

	reg [6:0] state_reg;
	reg [31:0] tbase_reg;
	reg burst_only_reg;
	reg mask_reg;
	reg enable_reg;
	reg alt_reg;
	reg [31:0] src_end_reg;
	reg [31:0] dst_end_reg;
	reg [31:0] ctl_reg;
	reg [31:0] data_reg;
	reg [15:0] budget_reg;
	reg burst_sel_reg;
	reg pingpong_reg;
	reg hw_dis_reg;
	reg alt_tog_reg;
	reg ph_wr_reg;
	reg ph_act_reg;
	reg [11:0] ph_addr_reg;
	reg [31:0] acc_addr;
	reg [1:0] acc_size;
	reg [31:0] rd_mux;
	wire [31:0] sbase;
	wire alt_now;
	wire single_ok;
	wire go;
	wire addr_phase;
	wire [9:0] cnt;

	// Address of the current item, counted back from the inclusive end
	// No wrap check: a count that reaches below the buffer start is a software fault
	function [31:0] item_addr;
		input [31:0] end_ptr;
		input [9:0] left;
		input [1:0] inc;
		begin
			if (inc == `INC_NONE)
				item_addr = end_ptr;
			else
				item_addr = end_ptr - ({22'h0, left} << inc);
		end
	endfunction

	// Register view of one per-channel flag: only this channel's bit can read as one
	function [31:0] chan_flag;
		input flag;
		begin
			if (flag)
				chan_flag = 32'h0000_0001 << CHAN;
			else
				chan_flag = 32'h0000_0000;
		end
	endfunction

	// Structure half in use; a toggle still in flight already counts, so that a
	// ping-pong refetch issued in the very next cycle reads the other structure
	assign alt_now = alt_reg ^ alt_tog_reg;
	// Structure start: table base on a 1 KiB boundary, alternate half, 16 bytes per channel
	assign sbase = {tbase_reg[31:10], alt_now, CHAN, 4'h0};
	assign cnt = ctl_reg[`F_CNT];
	// A masked channel or a single request under burst-only is simply not seen
	assign single_ok = periph_single_req & ~burst_only_reg;
	// Pending hardware updates hold off a start until enable and alternate have settled
	assign go = enable_reg & ~mask_reg & (periph_burst_req | single_ok) & ~hw_dis_reg &
		~alt_tog_reg;
	assign addr_phase = hsel & htrans[1] & hready;

	// Access address and size for the access the current state makes
	// Structure words are always whole words; items take their size from the control word
	always @* begin
		acc_size = `SIZE_WORD;
		case (state_reg)
			S_FSRC: acc_addr = sbase | `SRC_OFS;
			S_FDST: acc_addr = sbase | `DST_OFS;
			S_FCTL: acc_addr = sbase | `CTL_OFS;
			S_WB: acc_addr = sbase | `CTL_OFS;
			S_RD: begin
				acc_addr = item_addr(src_end_reg, cnt, ctl_reg[`F_SINC]);
				acc_size = ctl_reg[`F_SSIZE];
			end
			S_WR: begin
				acc_addr = item_addr(dst_end_reg, cnt, ctl_reg[`F_DINC]);
				acc_size = ctl_reg[`F_DSIZE];
			end
			default: acc_addr = 32'h0000_0000;
		endcase
	end

	// Transfer sequencer: fetch structure, move items, write the control word back
	// The control word is written back after every service that moves items, not only the last, so
	// software always sees the remaining count; the price is one extra access per structure served
	always @(posedge sys_clk) begin
		if (!nrst) begin
			state_reg <= S_IDLE;
			mem_req <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_write <= 1'b0;
			mem_size <= 2'h0;
			mem_wdata <= 32'h0000_0000;
			src_end_reg <= 32'h0000_0000;
			dst_end_reg <= 32'h0000_0000;
			ctl_reg <= 32'h0000_0000;
			data_reg <= 32'h0000_0000;
			budget_reg <= 16'h0000;
			burst_sel_reg <= 1'b0;
			pingpong_reg <= 1'b0;
			hw_dis_reg <= 1'b0;
			alt_tog_reg <= 1'b0;
			periph_done <= 1'b0;
			channel_active <= 1'b0;
		end else begin
			hw_dis_reg <= 1'b0;
			alt_tog_reg <= 1'b0;
			periph_done <= 1'b0;
			channel_active <= (state_reg != S_IDLE);
			if (state_reg == S_IDLE) begin
				// Requests are looked at only here; one that stays high starts the next service
				budget_reg <= 16'h0000;
				if (go) begin
					burst_sel_reg <= periph_burst_req;
					state_reg <= S_FSRC;
				end
			end else if (!mem_req) begin
				// One access at a time; the request holds until the memory answers
				mem_req <= 1'b1;
				mem_addr <= acc_addr;
				mem_write <= (state_reg == S_WR) | (state_reg == S_WB);
				mem_size <= acc_size;
				mem_wdata <= (state_reg == S_WB) ? ctl_reg : data_reg;
			end else if (mem_ready) begin
				mem_req <= 1'b0;
				case (state_reg)
					S_FSRC: begin
						src_end_reg <= mem_rdata;
						state_reg <= S_FDST;
					end
					S_FDST: begin
						dst_end_reg <= mem_rdata;
						state_reg <= S_FCTL;
					end
					S_FCTL: begin
						ctl_reg <= mem_rdata;
						pingpong_reg <= (mem_rdata[`F_OP] == `OP_PINGPONG);
						if (mem_rdata[`F_OP] == `OP_BASIC ||
							mem_rdata[`F_OP] == `OP_PINGPONG) begin
							// Budget only set fresh; a ping-pong switch keeps what is left
							if (budget_reg == 16'h0000) begin
								if (burst_sel_reg)
									budget_reg <= 16'h0001 << mem_rdata[`F_ARB];
								else
									budget_reg <= 16'h0001;
							end
							state_reg <= S_RD;
						end else begin
							// Stopped or unsupported structure: give the channel up
							hw_dis_reg <= 1'b1;
							state_reg <= S_IDLE;
						end
					end
					S_RD: begin
						data_reg <= mem_rdata;
						state_reg <= S_WR;
					end
					S_WR: begin
						// A count reaching zero ends the structure whatever budget is left
						budget_reg <= budget_reg - 16'h0001;
						if (cnt == 10'h000) begin
							ctl_reg[`F_OP] <= `OP_STOP;
							state_reg <= S_WB;
						end else begin
							ctl_reg[`F_CNT] <= cnt - 10'h001;
							state_reg <= (budget_reg == 16'h0001) ? S_WB : S_RD;
						end
					end
					S_WB: begin
						state_reg <= S_IDLE;
						if (ctl_reg[`F_OP] == `OP_STOP) begin
							periph_done <= 1'b1;
							if (pingpong_reg) begin
								alt_tog_reg <= 1'b1;
								// Carry on with the other buffer inside the same service
								// alt_now already points at it, so no idle cycle is spent
								if (budget_reg != 16'h0000)
									state_reg <= S_FSRC;
							end else begin
								hw_dis_reg <= 1'b1;
							end
						end
					end
					default: state_reg <= S_IDLE;
				endcase
			end
		end
	end

	// Read data for the register map, latched in the address phase
	always @* begin
		case (haddr[11:0])
			`R_STATUS: rd_mux = {25'h0, state_reg};
			`R_TBASE: rd_mux = {tbase_reg[31:10], 10'h000};
			`R_BURST_SET: rd_mux = chan_flag(burst_only_reg);
			`R_MASK_SET: rd_mux = chan_flag(mask_reg);
			`R_EN_SET: rd_mux = chan_flag(enable_reg);
			`R_ALT_SET: rd_mux = chan_flag(alt_reg);
			`R_PRIO_SET: rd_mux = chan_flag(high_priority);
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// AHB-Lite slave: zero wait states, OKAY always, unmapped reads zero and writes dropped
	// hreadyout is a flop held at one, so wait states can come later without a port change
	always @(posedge sys_clk) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ph_act_reg <= 1'b0;
			ph_wr_reg <= 1'b0;
			ph_addr_reg <= 12'h000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ph_act_reg <= addr_phase;
			ph_wr_reg <= addr_phase & hwrite;
			if (addr_phase) begin
				ph_addr_reg <= haddr[11:0];
				if (!hwrite)
					hrdata <= rd_mux;
			end
		end
	end

	// Channel control bits; a software set wins over a same-cycle hardware clear
	// Hardware updates arrive one cycle late from flags, so a bus write in that cycle decides
	always @(posedge sys_clk) begin
		if (!nrst) begin
			tbase_reg <= `RST_TBASE;
			burst_only_reg <= `RST_BIT;
			mask_reg <= `RST_BIT;
			enable_reg <= `RST_BIT;
			alt_reg <= `RST_BIT;
			high_priority <= `RST_BIT;
		end else begin
			if (hw_dis_reg)
				enable_reg <= 1'b0;
			if (alt_tog_reg)
				alt_reg <= ~alt_reg;
			if (ph_act_reg && ph_wr_reg) begin
				case (ph_addr_reg)
					`R_TBASE: tbase_reg <= {hwdata[31:10], 10'h000};
					`R_BURST_SET: if (hwdata[CHAN])
						burst_only_reg <= 1'b1;
					`R_BURST_CLR: if (hwdata[CHAN])
						burst_only_reg <= 1'b0;
					`R_MASK_SET: if (hwdata[CHAN])
						mask_reg <= 1'b1;
					`R_MASK_CLR: if (hwdata[CHAN])
						mask_reg <= 1'b0;
					`R_EN_SET: if (hwdata[CHAN])
						enable_reg <= 1'b1;
					`R_EN_CLR: if (hwdata[CHAN])
						enable_reg <= 1'b0;
					`R_ALT_SET: if (hwdata[CHAN])
						alt_reg <= 1'b1;
					`R_ALT_CLR: if (hwdata[CHAN])
						alt_reg <= 1'b0;
					`R_PRIO_SET: if (hwdata[CHAN])
						high_priority <= 1'b1;
					`R_PRIO_CLR: if (hwdata[CHAN])
						high_priority <= 1'b0;
					default: tbase_reg <= tbase_reg;
				endcase
			end
		end
	end

endmodule

/* File: rtl/dma_channel_defines.vh */
// Constants for the single DMA channel engine: fields, offsets, reset values
`ifndef DMA_CHANNEL_DEFINES_VH
`define DMA_CHANNEL_DEFINES_VH
// Control word fields
`define F_DINC 31:30
`define F_DSIZE 29:28
`define F_SINC 27:26
`define F_SSIZE 25:24
`define F_ARB 17:14
`define F_CNT 13:4
`define F_NXTBURST 3
`define F_OP 2:0
// Operation codes and increment codes
`define OP_STOP 3'h0
`define OP_BASIC 3'h1
`define OP_PINGPONG 3'h3
`define INC_NONE 2'h3
`define SIZE_WORD 2'h2
// Word offsets inside one control structure
`define SRC_OFS 32'h0000_0000
`define DST_OFS 32'h0000_0004
`define CTL_OFS 32'h0000_0008
// Register byte offsets
`define R_STATUS 12'h000
`define R_TBASE 12'h008
`define R_BURST_SET 12'h018
`define R_BURST_CLR 12'h01c
`define R_MASK_SET 12'h020
`define R_MASK_CLR 12'h024
`define R_EN_SET 12'h028
`define R_EN_CLR 12'h02c
`define R_ALT_SET 12'h030
`define R_ALT_CLR 12'h034
`define R_PRIO_SET 12'h038
`define R_PRIO_CLR 12'h03c
// Reset values
`define RST_TBASE 32'h0000_0000
`define RST_BIT 1'b0
`endif

/* File: tb/dma_channel_monitor.sv */
// Port checker for the DMA channel
`timescale 1ns/100ps
module dma_channel_monitor #(parameter [4:0] CHAN = 5'd8) (
	input wire sys_clk, // Clock
	input wire nrst, // Reset
	input wire hsel, // Select
	input wire [31:0] haddr, // Address
	input wire [1:0] htrans, // Type
	input wire hwrite, // Write
	input wire [31:0] hwdata, // Wdata
	input wire hready, // Ready
	input wire mem_req, // Mem request
	input wire [31:0] mem_addr, // Mem address
	input wire mem_write, // Mem write
	input wire [1:0] mem_size, // Item size
	input wire mem_ready, // Mem done
	input wire periph_done, // Done pulse
	input wire high_priority // Priority
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	reg [31:0] last_addr;
	reg last_wr;
	wire aw = hsel && htrans == 2'h2 && hwrite && hready;
	// Last finished access; done must follow a control write-back
	always @(posedge sys_clk) begin
		if (!nrst) begin
			last_addr <= 32'h0;
			last_wr <= 1'b0;
		end else if (mem_req && mem_ready) begin
			last_addr <= mem_addr;
			last_wr <= mem_write;
		end
	end
	property p_hold; mem_req && !mem_ready |=> mem_req && $stable(mem_addr); endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_slot; mem_req && mem_size == 2'h2 |-> mem_addr[8:4] == CHAN && mem_addr[3:2] != 2'h3;
	endproperty
	a_slot: assert property (p_slot) else $error("bad table slot");
	property p_step; $rose(mem_req) && !mem_write && mem_size == 2'h2 && mem_addr[3:0] == 4'h4
		|-> last_addr == mem_addr - 32'h4; endproperty
	a_step: assert property (p_step) else $error("bad fetch order");
	property p_wb; periph_done |-> last_wr && last_addr[3:0] == 4'h8; endproperty
	a_wb: assert property (p_wb) else $error("done without write-back");
	property p_pulse; periph_done |=> !periph_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_pset; aw && haddr[11:0] == 12'h038 ##1 hwdata[CHAN] |=> high_priority; endproperty
	a_pset: assert property (p_pset) else $error("priority not set");
	property p_pclr; aw && haddr[11:0] == 12'h03c ##1 hwdata[CHAN] |=> !high_priority; endproperty
	a_pclr: assert property (p_pclr) else $error("priority not cleared");
	property p_byte; mem_req && mem_size != 2'h2 |-> mem_size == 2'h0; endproperty
	a_byte: assert property (p_byte) else $error("bad item size");
endmodule
bind dma_channel dma_channel_monitor #(.CHAN(CHAN)) u_mon (.sys_clk, .nrst, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .mem_req, .mem_addr, .mem_write, .mem_size, .mem_ready,
	.periph_done, .high_priority);

/* File: tb/dma_mem_model.sv */
// System memory: control table, buffers and peripheral FIFO registers
`timescale 1ns/100ps
module dma_mem_model (
	input wire sys_clk, // Clock
	input wire mem_req, // Request
	input wire [31:0] mem_addr, // Address
	input wire mem_write, // Write
	input wire [1:0] mem_size, // Size
	input wire [31:0] mem_wdata, // Wdata
	output logic mem_ready, // Done
	output wire [31:0] mem_rdata // Rdata
);
	logic [7:0] m [0:1023];
	logic [31:0] rd = 32'h0;
	int slow = 0;
	int cnt = 0;
	int nbytes = 0;
	wire [9:0] a = mem_addr[9:0];
	// Scrambled outside ready so a late capture shows
	assign mem_rdata = mem_ready ? rd : ~rd;
	// Waits slow cycles before answering, to stall the engine
	always @(posedge sys_clk) begin
		mem_ready <= 1'b0;
		if (mem_req && !mem_ready) begin
			if (cnt < slow) cnt <= cnt + 1;
			else begin
				cnt <= 0;
				mem_ready <= 1'b1;
				rd <= mem_size == 2'h2 ? {m[a+3], m[a+2], m[a+1], m[a]} : {24'h0, m[a]};
				if (mem_write && mem_size == 2'h2) {m[a+3], m[a+2], m[a+1], m[a]} <= mem_wdata;
				if (mem_write && mem_size == 2'h0) begin
					m[a] <= mem_wdata[7:0];
					nbytes <= nbytes + 1;
				end
			end
		end
	end
endmodule

/* File: tb/dma_channel_tb_top.sv */
// Self-checking bench for the DMA channel engine
`timescale 1ns/100ps
module dma_channel_tb_top;
	logic sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, sreq = 0, breq = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, mem_addr, mem_wdata, mem_rdata, r;
	logic [1:0] htrans = 0, mem_size;
	logic hreadyout, hresp, mem_req, mem_write, mem_ready, periph_done, high_priority;
	logic channel_active;
	int error_cnt = 0, n_checks = 0, ndone = 0, i;
	typedef struct {logic [11:0] wa; logic [11:0] ra; logic [31:0] e;} row_t;
	// Write ones, read back: set/clear pairs, read-only status, unmapped
	row_t rows [10] = '{'{12'h038, 12'h038, 32'h100}, '{12'h03c, 12'h038, 32'h0},
		'{12'h018, 12'h018, 32'h100}, '{12'h01c, 12'h018, 32'h0}, '{12'h020, 12'h020, 32'h100},
		'{12'h024, 12'h020, 32'h0}, '{12'h030, 12'h030, 32'h100}, '{12'h034, 12'h030, 32'h0},
		'{12'h000, 12'h000, 32'h1}, '{12'h0f0, 12'h0f0, 32'h0}};
	initial forever #25 sys_clk = ~sys_clk;
	dma_channel DUT (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_addr, .mem_write,
		.mem_size, .mem_wdata, .mem_ready, .mem_rdata, .periph_single_req(sreq),
		.periph_burst_req(breq), .periph_done, .high_priority, .channel_active);
	dma_mem_model u_mem (.sys_clk, .mem_req, .mem_addr, .mem_write, .mem_size, .mem_wdata,
		.mem_ready, .mem_rdata);
	always @(posedge sys_clk) if (periph_done === 1'b1) ndone <= ndone + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Single transfer; each phase is held until hready is seen high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic poke(input int a, input logic [31:0] d);
		{u_mem.m[a+3], u_mem.m[a+2], u_mem.m[a+1], u_mem.m[a]} = d;
	endtask
	function automatic logic [31:0] peek(input int a);
		return {u_mem.m[a+3], u_mem.m[a+2], u_mem.m[a+1], u_mem.m[a]};
	endfunction
	// Requests are sampled only while idle, so drop once the engine starts
	task automatic serve(input logic b);
		if (b) breq <= 1;
		else sreq <= 1;
		for (i = 0; i < 50 && channel_active !== 1'b1; i++) @(posedge sys_clk);
		breq <= 0;
		sreq <= 0;
		for (i = 0; i < 900 && channel_active !== 1'b0; i++) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge sys_clk);
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1;
		bus(0, 12'h028, 0);
		chk(r, 32'h0);
		chk({31'h0, high_priority}, 32'h0);
		$display("test reset done");
		foreach (rows[k]) begin
			bus(1, rows[k].wa, 32'hffff_ffff);
			bus(0, rows[k].ra, 0);
			chk(r, rows[k].e);
		end
		$display("test registers done");
		// Basic: five bytes to a fixed FIFO register, slow memory
		for (i = 0; i < 5; i++) u_mem.m[256+i] = 8'ha0 + i;
		poke(12'h080, 32'h104);
		poke(12'h084, 32'h1f0);
		poke(12'h088, 32'hc000_8041);
		u_mem.slow = 2;
		bus(1, 12'h018, 32'h100);
		bus(1, 12'h028, 32'h100);
		sreq <= 1;
		repeat (20) @(posedge sys_clk);
		sreq <= 0;
		chk(u_mem.nbytes, 0);
		serve(1);
		chk(u_mem.nbytes, 4);
		chk(u_mem.m[12'h1f0], 8'ha3);
		bus(1, 12'h01c, 32'h100);
		serve(0);
		chk(u_mem.nbytes, 5);
		chk(u_mem.m[12'h1f0], 8'ha4);
		chk(peek(12'h088) & 32'hffff_c007, 32'hc000_8000);
		bus(0, 12'h028, 0);
		chk(r, 0);
		chk(ndone, 1);
		$display("test basic done");
		// Ping-pong: three 2-byte buffers filled in one burst service
		poke(12'h080, 32'h1f4);
		poke(12'h084, 32'h201);
		poke(12'h088, 32'h0c00_c013);
		poke(12'h280, 32'h1f4);
		poke(12'h284, 32'h211);
		poke(12'h288, 32'h0c00_c013);
		u_mem.m[12'h1f4] = 8'h5a;
		u_mem.slow = 0;
		bus(1, 12'h028, 32'h100);
		// Primary is reprogrammed while the alternate runs, so a third buffer follows
		fork
			serve(1);
			begin
				@(posedge periph_done);
				poke(12'h088, 32'h0c00_c013);
			end
		join
		chk(u_mem.nbytes, 11);
		chk(peek(12'h210) & 32'hffff, 32'h5a5a);
		chk(peek(12'h088) & 32'h7, 0);
		chk(peek(12'h288) & 32'h7, 0);
		chk(ndone, 4);
		bus(0, 12'h030, 0);
		chk(r, 32'h100);
		$display("test ping-pong done");
		// Mid-run reset: settings fall back and the bus answers right after release
		bus(1, 12'h038, 32'h100);
		bus(1, 12'h028, 32'h100);
		nrst <= 0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1;
		@(posedge sys_clk);
		chk({31'h0, high_priority}, 32'h0);
		bus(0, 12'h028, 0);
		chk(r, 32'h0);
		$display("test mid-run reset done");
		print_verdict;
	end
endmodule
